// File: include/ledfs_pkg.sv
// Purpose: constants and types of the led channel fault status block
// Assumes: byte wide register port driven by the serial bus front end
// Notes: variant b is the standalone build, variant a the bus driven build
package ledfs_pkg;
   localparam logic [7:0] ADDR_DEV_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_DEV_CONFIG = 8'h01;
   localparam logic [7:0] ADDR_CHAN_CFG = 8'h11;
   localparam logic [7:0] ADDR_OUT_CFG = 8'h12;
   localparam logic [7:0] ADDR_BOOST_CFG = 8'h13;
   localparam logic [7:0] ADDR_FM_CFG = 8'h15;
   localparam logic [7:0] ADDR_FAULT_MASK = 8'h16;
   localparam logic [7:0] ADDR_DEV_STATUS = 8'h17;
   localparam logic [7:0] ADDR_CHAN_STATUS = 8'h18;
   localparam logic [7:0] ADDR_STARTUP_STATUS = 8'h19;
   // field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_CLEAR = 0;
   localparam int BIT_OPEN_AUTO_DISCONNECT = 3;
   localparam int BIT_FAULT_LATCH_SELECT = 4;
   localparam int BIT_THSD = 1;
   localparam int BIT_OOVP = 2;
   localparam int BIT_LED_FAULT_FLAG = 3;
   localparam int BIT_OTEA = 4;
   localparam int BIT_STARTUP_CHECK_FLAG = 5;
   localparam int BIT_IOVP = 6;
   localparam int BIT_IOCP = 7;
   // writable bits of the masked registers; the output configuration register takes all eight bits
   localparam logic [7:0] MASK_CHAN_CFG = 8'h7f;
   localparam logic [7:0] MASK_BOOST_CFG = 8'hf7;
   localparam logic [7:0] MASK_FM_CFG = 8'h3e;
   localparam logic [7:0] MASK_FLAGS = 8'hfe;
   localparam logic [7:0] FM_CFG_FIXED = 8'h01;
   // reset values, bus-driven variant then standalone variant
   localparam logic [7:0] RST_A_CHAN_CFG = 8'h0f;
   localparam logic [7:0] RST_B_CHAN_CFG = 8'h7f;
   localparam logic [7:0] RST_A_OUT_CFG = 8'h00;
   localparam logic [7:0] RST_B_OUT_CFG = 8'h3e;
   localparam logic [7:0] RST_A_BOOST_CFG = 8'h00;
   localparam logic [7:0] RST_B_BOOST_CFG = 8'h06;
   localparam logic [7:0] RST_A_FM_CFG = 8'h01;
   localparam logic [7:0] RST_B_FM_CFG = 8'h29;
   localparam logic [7:0] RST_A_FAULT_MASK = 8'h00;
   localparam logic [7:0] RST_B_FAULT_MASK = 8'h10;
   localparam logic RST_A_ENABLE = 1'b0;
   localparam logic RST_B_ENABLE = 1'b1;
   localparam logic [7:0] RST_STATUS = 8'h00;

   typedef enum logic [2:0] {
      LEDFS_INIT = 3'b001,
      LEDFS_STBY = 3'b010,
      LEDFS_RUN = 3'b100
   } ledfs_mode_t;

   // one detection result, laid out as the channel status register
   typedef struct packed {
      logic [3:0] shorted;
      logic [3:0] open;
   } ledfs_det_t;

   // startup check result, laid out as the startup check status register
   typedef struct packed {
      logic current_set_pin;
      logic [2:0] adj;
      logic [3:0] gnd;
   } ledfs_init_t;

   // live conditions of the other fault sources
   typedef struct packed {
      logic iocp;
      logic iovp;
      logic otea;
      logic oovp;
      logic thsd;
   } ledfs_alarm_t;
endpackage

// File: hdl/ledfs_fault_status.sv
// Purpose: fault status registers, device status flags and fault output
// Assumes: register port and analog detectors are synchronous to mclk
// Notes: VARIANT_B selects the standalone reset defaults
`timescale 1ns/100ps
module ledfs_fault_status
   import ledfs_pkg::*;
#(
   parameter bit VARIANT_B = 1'b0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic det_valid,
   input wire ledfs_det_t det_result,
   input wire logic init_done,
   input wire ledfs_init_t init_result,
   input wire ledfs_alarm_t alarm,
   output logic [3:0] chan_active,
   output logic run_mode,
   output logic fault_out
);
   ledfs_mode_t mode_q;
   logic [7:0] chan_cfg_q;
   logic [7:0] out_cfg_q;
   logic [7:0] boost_cfg_q;
   logic [7:0] fm_cfg_q;
   logic [7:0] fault_mask_q;
   logic enable_q;
   ledfs_det_t chan_status_q;
   ledfs_init_t startup_q;
   logic [7:0] dev_status_q;
   logic [7:0] dev_status_d;
   logic [3:0] disc_q;
   logic [3:0] on_mask;
   ledfs_det_t det_masked;
   ledfs_init_t init_masked;
   ledfs_det_t chan_status_d;
   ledfs_init_t startup_d;
   logic [7:0] live_flags;
   logic [7:0] rdata_d;
   logic det_go;
   logic init_go;
   logic clr_wr;
   logic wr_chan;
   logic wr_out;
   logic wr_boost;
   logic wr_fm;
   logic wr_mask;
   logic wr_en;
   logic fault_d;

   // write strobes and event qualifiers
   assign wr_en = reg_wr && reg_addr == ADDR_DEV_ENABLE;
   assign clr_wr = reg_wr && reg_addr == ADDR_DEV_CONFIG && reg_wdata[BIT_CLEAR];
   assign wr_chan = reg_wr && reg_addr == ADDR_CHAN_CFG;
   assign wr_out = reg_wr && reg_addr == ADDR_OUT_CFG;
   assign wr_boost = reg_wr && reg_addr == ADDR_BOOST_CFG;
   assign wr_fm = reg_wr && reg_addr == ADDR_FM_CFG;
   assign wr_mask = reg_wr && reg_addr == ADDR_FAULT_MASK;
   assign det_go = det_valid && mode_q == LEDFS_RUN;
   assign init_go = init_done && mode_q == LEDFS_INIT;

   // per channel gating of detector results
   for (genvar i = 0; i < 4; i++) begin : g_chan
      assign on_mask[i] = chan_cfg_q[i] && !disc_q[i];
      assign det_masked.open[i] = det_result.open[i] && on_mask[i];
      assign det_masked.shorted[i] = det_result.shorted[i] && on_mask[i];
      assign init_masked.gnd[i] = init_result.gnd[i] && chan_cfg_q[i];
   end
   assign init_masked.adj = init_result.adj & ~chan_cfg_q[6:4];
   assign init_masked.current_set_pin = init_result.current_set_pin;

   // next status: a new event wins over a clear in the same cycle
   always_comb begin
      chan_status_d = chan_status_q;
      startup_d = startup_q;
      if (det_go) begin
         chan_status_d = det_masked;
      end else if (clr_wr) begin
         chan_status_d = '0;
      end
      if (init_go) begin
         startup_d = init_masked;
      end else if (clr_wr) begin
         startup_d = '0;
      end
   end

   // live conditions in device status layout
   assign live_flags = {alarm.iocp, alarm.iovp, |startup_d, alarm.otea, |chan_status_d, alarm.oovp, alarm.thsd, 1'b0};

   // latched device status flags
   always_comb begin
      dev_status_d = (clr_wr ? 8'h00 : dev_status_q) | live_flags;
   end

   // fault output: real-time or latched, each flag gated by its mask
   always_comb begin
      if (fm_cfg_q[BIT_FAULT_LATCH_SELECT]) begin
         fault_d = |(dev_status_d & ~fault_mask_q & MASK_FLAGS);
      end else begin
         fault_d = |(live_flags & ~fault_mask_q & MASK_FLAGS);
      end
   end

   // status registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         chan_status_q <= RST_STATUS;
         startup_q <= RST_STATUS;
         dev_status_q <= RST_STATUS;
         fault_out <= 1'b0;
      end else begin
         chan_status_q <= chan_status_d;
         startup_q <= startup_d;
         dev_status_q <= dev_status_d & MASK_FLAGS;
         fault_out <= fault_d;
      end
   end

   // configuration registers; detection never writes them
   always_ff @(posedge mclk) begin
      if (rst) begin
         chan_cfg_q <= VARIANT_B ? RST_B_CHAN_CFG : RST_A_CHAN_CFG;
         out_cfg_q <= VARIANT_B ? RST_B_OUT_CFG : RST_A_OUT_CFG;
         boost_cfg_q <= VARIANT_B ? RST_B_BOOST_CFG : RST_A_BOOST_CFG;
         fm_cfg_q <= VARIANT_B ? RST_B_FM_CFG : RST_A_FM_CFG;
         fault_mask_q <= VARIANT_B ? RST_B_FAULT_MASK : RST_A_FAULT_MASK;
         enable_q <= VARIANT_B ? RST_B_ENABLE : RST_A_ENABLE;
      end else begin
         if (wr_chan) begin
            chan_cfg_q <= reg_wdata & MASK_CHAN_CFG;
         end
         if (wr_out) begin
            out_cfg_q <= reg_wdata;
         end
         if (wr_boost) begin
            boost_cfg_q <= reg_wdata & MASK_BOOST_CFG;
         end
         if (wr_fm) begin
            fm_cfg_q <= (reg_wdata & MASK_FM_CFG) | FM_CFG_FIXED;
         end
         if (wr_mask) begin
            fault_mask_q <= reg_wdata & MASK_FLAGS;
         end
         if (wr_en) begin
            enable_q <= reg_wdata[BIT_ENABLE];
         end
      end
   end

   // open channel auto disconnection, released by clear_flags
   always_ff @(posedge mclk) begin
      if (rst) begin
         disc_q <= 4'h0;
      end else if (det_go && fm_cfg_q[BIT_OPEN_AUTO_DISCONNECT]) begin
         disc_q <= disc_q | det_masked.open;
      end else if (clr_wr) begin
         disc_q <= 4'h0;
      end
   end

   // startup, standby and operation sequencing
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_q <= LEDFS_INIT;
      end else begin
         case (mode_q)
            LEDFS_INIT: begin
               if (init_go) begin
                  mode_q <= LEDFS_STBY;
               end
            end
            LEDFS_STBY: begin
               if (enable_q && startup_q == RST_STATUS && !init_go) begin
                  mode_q <= LEDFS_RUN;
               end
            end
            LEDFS_RUN: begin
               if (!enable_q) begin
                  mode_q <= LEDFS_STBY;
               end
            end
            default: begin
               mode_q <= LEDFS_INIT;
            end
         endcase
      end
   end

   // channel drive and mode outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         chan_active <= 4'h0;
         run_mode <= 1'b0;
      end else begin
         chan_active <= (mode_q == LEDFS_RUN) ? on_mask : 4'h0;
         run_mode <= mode_q == LEDFS_RUN;
      end
   end

   // read decode; unmapped addresses read 00h
   always_comb begin
      if (reg_addr == ADDR_DEV_ENABLE) begin
         rdata_d = {7'h00, enable_q};
      end else if (reg_addr == ADDR_CHAN_CFG) begin
         rdata_d = chan_cfg_q;
      end else if (reg_addr == ADDR_OUT_CFG) begin
         rdata_d = out_cfg_q;
      end else if (reg_addr == ADDR_BOOST_CFG) begin
         rdata_d = boost_cfg_q;
      end else if (reg_addr == ADDR_FM_CFG) begin
         rdata_d = fm_cfg_q;
      end else if (reg_addr == ADDR_FAULT_MASK) begin
         rdata_d = fault_mask_q;
      end else if (reg_addr == ADDR_DEV_STATUS) begin
         rdata_d = dev_status_q;
      end else if (reg_addr == ADDR_CHAN_STATUS) begin
         rdata_d = chan_status_q;
      end else if (reg_addr == ADDR_STARTUP_STATUS) begin
         rdata_d = startup_q;
      end else begin
         rdata_d = 8'h00;
      end
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_d;
         end
      end
   end

   // checks
   property p_off_zero;
      @(posedge mclk) disable iff (rst) det_go |=> (chan_status_q.open & ~chan_cfg_q[3:0]) == 4'h0 &&
         (chan_status_q.shorted & ~chan_cfg_q[3:0]) == 4'h0;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("disabled channel shows a fault");
   property p_overwrite;
      @(posedge mclk) disable iff (rst) det_go |=> chan_status_q == $past(det_masked);
   endproperty
   a_overwrite: assert property (p_overwrite) else $error("channel status not overwritten");
   property p_led_fault_flag;
      @(posedge mclk) disable iff (rst) chan_status_q != 8'h00 |-> dev_status_q[BIT_LED_FAULT_FLAG];
   endproperty
   a_led_fault_flag: assert property (p_led_fault_flag) else $error("led fault flag missing");
   property p_clear;
      @(posedge mclk) disable iff (rst) clr_wr && !det_go && !init_go |=> chan_status_q == 8'h00 && startup_q == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not clear status");
   property p_cfg_kept;
      @(posedge mclk) disable iff (rst) det_go && !wr_chan |=> $stable(chan_cfg_q);
   endproperty
   a_cfg_kept: assert property (p_cfg_kept) else $error("detection changed configuration");
   property p_latch;
      @(posedge mclk) disable iff (rst) dev_status_q[BIT_STARTUP_CHECK_FLAG] && !clr_wr |=> dev_status_q[BIT_STARTUP_CHECK_FLAG];
   endproperty
   a_latch: assert property (p_latch) else $error("status flag dropped");
   property p_latched_out;
      @(posedge mclk) disable iff (rst) fm_cfg_q[BIT_FAULT_LATCH_SELECT] && !reg_wr &&
         (dev_status_q & ~fault_mask_q & MASK_FLAGS) != 8'h00 |=> fault_out;
   endproperty
   a_latched_out: assert property (p_latched_out) else $error("latched fault output low");
   property p_hold_stby;
      @(posedge mclk) disable iff (rst) mode_q == LEDFS_STBY && startup_q != 8'h00 |=> mode_q != LEDFS_RUN;
   endproperty
   a_hold_stby: assert property (p_hold_stby) else $error("left standby with startup fault");
   property p_disc;
      @(posedge mclk) disable iff (rst) det_go && fm_cfg_q[BIT_OPEN_AUTO_DISCONNECT] |=> ##1 (chan_active & $past(det_masked.open, 2)) == 4'h0;
   endproperty
   a_disc: assert property (p_disc) else $error("open channel still driven");
   property p_startup_check_flag;
      @(posedge mclk) disable iff (rst) init_go && init_masked != 8'h00 |=> dev_status_q[BIT_STARTUP_CHECK_FLAG];
   endproperty
   a_startup_check_flag: assert property (p_startup_check_flag) else $error("startup check flag missing");
   property p_idle_off;
      @(posedge mclk) disable iff (rst) mode_q != LEDFS_RUN |=> chan_active == 4'h0 && !run_mode;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("channels driven outside operation");
   property p_mask_out;
      @(posedge mclk) disable iff (rst) (dev_status_d & ~fault_mask_q & MASK_FLAGS) == 8'h00 |=> !fault_out;
   endproperty
   a_mask_out: assert property (p_mask_out) else $error("masked flag raised the fault output");
   property p_status_read;
      @(posedge mclk) disable iff (rst) reg_rvalid && $past(reg_addr) == ADDR_CHAN_STATUS |->
         reg_rdata == $past(chan_status_q);
   endproperty
   a_status_read: assert property (p_status_read) else $error("channel status read wrong");
   c_run: cover property (@(posedge mclk) disable iff (rst) mode_q == LEDFS_STBY ##1 mode_q == LEDFS_RUN);
   c_fault: cover property (@(posedge mclk) disable iff (rst) det_go ##1 fault_out);
   c_clear: cover property (@(posedge mclk) disable iff (rst) fault_out ##1 clr_wr ##1 !fault_out);
   c_disc: cover property (@(posedge mclk) disable iff (rst) det_go && fm_cfg_q[BIT_OPEN_AUTO_DISCONNECT] && det_masked.open != 4'h0);
endmodule

// File: dv/ledfs_host_model.sv
// Purpose: host model that reads status and writes configuration bytes
// Assumes: one strobe per access, read answer stands one cycle after the strobe
// Notes: address and data are inverted when idle so stale values never pass
`timescale 1ns/100ps
module ledfs_host_model (
   input wire logic mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // quiet bus from time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hff;
      reg_wdata = 8'hff;
   end
   // one write strobe held over the edge that takes it
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge mclk);
      #1;
      reg_wr = 1'b1;
      reg_addr = addr;
      reg_wdata = data;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask
   // one read strobe; answer taken while the valid pulse stands
   task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge mclk);
      #1;
      reg_rd = 1'b1;
      reg_addr = addr;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~addr;
      ok = reg_rvalid;
      data = reg_rdata;
   endtask
endmodule

// File: dv/tb_top.sv
// Purpose: self-checking bench for the fault status block
// Assumes: a bus-driven and a standalone instance share clock, reset and detector inputs except the startup pulse
// Notes: all register traffic goes through the host model
`timescale 1ns/100ps
module tb_top import ledfs_pkg::*;;
   logic mclk, rst, reg_wr, reg_rd, reg_rvalid, det_valid, init_done, run_mode, fault_out, rd_ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data;
   logic [3:0] chan_active;
   logic reg_wr_b, reg_rd_b, reg_rvalid_b, init_done_b, run_mode_b, fault_out_b;
   logic [7:0] reg_addr_b, reg_wdata_b, reg_rdata_b;
   logic [3:0] chan_active_b;
   ledfs_det_t det_result;
   ledfs_init_t init_result;
   ledfs_alarm_t alarm;
   int num_errors = 0;
   int checks = 0;
   ledfs_fault_status #(.VARIANT_B(1'b0)) ledfs_fault_status_inst (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .det_valid(det_valid), .det_result(det_result), .init_done(init_done),
      .init_result(init_result), .alarm(alarm), .chan_active(chan_active), .run_mode(run_mode),
      .fault_out(fault_out));
   ledfs_host_model ledfs_host_model_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   // standalone variant; stays in startup until its own startup pulse
   ledfs_fault_status #(.VARIANT_B(1'b1)) ledfs_fault_status_b_inst (.mclk(mclk), .rst(rst), .reg_wr(reg_wr_b),
      .reg_rd(reg_rd_b), .reg_addr(reg_addr_b), .reg_wdata(reg_wdata_b), .reg_rdata(reg_rdata_b),
      .reg_rvalid(reg_rvalid_b), .det_valid(det_valid), .det_result(det_result), .init_done(init_done_b),
      .init_result(init_result), .alarm(alarm), .chan_active(chan_active_b), .run_mode(run_mode_b),
      .fault_out(fault_out_b));
   ledfs_host_model ledfs_host_model_b_inst (.mclk(mclk), .reg_wr(reg_wr_b), .reg_rd(reg_rd_b),
      .reg_addr(reg_addr_b), .reg_wdata(reg_wdata_b), .reg_rdata(reg_rdata_b), .reg_rvalid(reg_rvalid_b));
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask
   // read a register and compare; the byte stays in rd_data
   task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
      ledfs_host_model_inst.rd(addr, rd_data, rd_ok);
      chk1({name, " valid"}, 1'b1, rd_ok);
      chk8(name, exp, rd_data);
   endtask
   // same read and compare on the standalone instance
   task automatic rdchk_b(input string name, input logic [7:0] addr, input logic [7:0] exp);
      ledfs_host_model_b_inst.rd(addr, rd_data, rd_ok);
      chk1({name, " valid"}, 1'b1, rd_ok);
      chk8(name, exp, rd_data);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // one detection pulse
   task automatic det(input logic [7:0] v);
      @(posedge mclk);
      #1;
      det_valid = 1'b1;
      det_result = v;
      @(posedge mclk);
      #1;
      det_valid = 1'b0;
      det_result = ~v;
      idle(2);
   endtask
   task automatic clear_all;
      ledfs_host_model_inst.wr(ADDR_DEV_CONFIG, 8'h01);
      idle(3);
   endtask
   task automatic t_reset;
      rdchk("chan status", ADDR_CHAN_STATUS, 8'h00);
      rdchk("startup status", ADDR_STARTUP_STATUS, 8'h00);
      rdchk("dev status", ADDR_DEV_STATUS, 8'h00);
      rdchk("chan cfg", ADDR_CHAN_CFG, 8'h0f);
      chk1("run mode", 1'b0, run_mode);
      ledfs_host_model_inst.wr(ADDR_CHAN_STATUS, 8'hff);
      ledfs_host_model_inst.wr(ADDR_STARTUP_STATUS, 8'hff);
      rdchk("chan status ro", ADDR_CHAN_STATUS, 8'h00);
      rdchk("startup status ro", ADDR_STARTUP_STATUS, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_startup;
      @(posedge mclk);
      #1;
      init_done = 1'b1;
      init_result = 8'hff;
      @(posedge mclk);
      #1;
      init_done = 1'b0;
      init_result = 8'h00;
      idle(3);
      rdchk("startup status", ADDR_STARTUP_STATUS, 8'hff);
      chk8("adjacent bits", 8'h07, {5'h00, rd_data[6:4]});
      chk1("resistor bit", 1'b1, rd_data[7]);
      rdchk("dev status", ADDR_DEV_STATUS, 8'h20);
      chk1("fault out", 1'b1, fault_out);
      ledfs_host_model_inst.wr(ADDR_DEV_ENABLE, 8'h01);
      idle(3);
      chk1("held in standby", 1'b0, run_mode);
      ledfs_host_model_inst.wr(ADDR_FAULT_MASK, 8'h20);
      idle(3);
      chk1("fault masked", 1'b0, fault_out);
      ledfs_host_model_inst.wr(ADDR_FAULT_MASK, 8'h00);
      clear_all();
      rdchk("startup cleared", ADDR_STARTUP_STATUS, 8'h00);
      rdchk("dev status cleared", ADDR_DEV_STATUS, 8'h00);
      chk1("fault cleared", 1'b0, fault_out);
      chk1("run mode", 1'b1, run_mode);
      chk8("channels", 8'h0f, {4'h0, chan_active});
      $display("test startup done");
   endtask
   task automatic t_detect;
      det(8'h21);
      rdchk("chan status", ADDR_CHAN_STATUS, 8'h21);
      rdchk("dev status", ADDR_DEV_STATUS, 8'h08);
      chk1("fault out", 1'b1, fault_out);
      rdchk("chan cfg kept", ADDR_CHAN_CFG, 8'h0f);
      det(8'h00);
      rdchk("chan status new", ADDR_CHAN_STATUS, 8'h00);
      rdchk("flag latched", ADDR_DEV_STATUS, 8'h08);
      chk1("real time fault", 1'b0, fault_out);
      clear_all();
      rdchk("dev status cleared", ADDR_DEV_STATUS, 8'h00);
      ledfs_host_model_inst.wr(ADDR_CHAN_CFG, 8'h0e);
      det(8'hff);
      rdchk("off channel bits", ADDR_CHAN_STATUS, 8'hee);
      chk8("channels", 8'h0e, {4'h0, chan_active});
      clear_all();
      $display("test detect done");
   endtask
   task automatic t_disconnect;
      ledfs_host_model_inst.wr(ADDR_CHAN_CFG, 8'h0f);
      ledfs_host_model_inst.wr(ADDR_FM_CFG, 8'h09);
      det(8'h04);
      chk8("disconnected", 8'h0b, {4'h0, chan_active});
      rdchk("open reported", ADDR_CHAN_STATUS, 8'h04);
      ledfs_host_model_inst.wr(ADDR_FM_CFG, 8'h11);
      det(8'h00);
      chk1("latched fault", 1'b1, fault_out);
      clear_all();
      chk1("fault cleared", 1'b0, fault_out);
      chk8("reconnected", 8'h0f, {4'h0, chan_active});
      ledfs_host_model_inst.wr(ADDR_DEV_ENABLE, 8'h00);
      idle(3);
      chk1("back to standby", 1'b0, run_mode);
      $display("test disconnect done");
   endtask
   // standalone defaults, startup fault cleared by the host, alarm masking, open disconnect
   task automatic t_standalone;
      rdchk_b("b enable", ADDR_DEV_ENABLE, 8'h01);
      rdchk_b("b chan cfg", ADDR_CHAN_CFG, 8'h7f);
      rdchk_b("b out cfg", ADDR_OUT_CFG, 8'h3e);
      rdchk_b("b boost cfg", ADDR_BOOST_CFG, 8'h06);
      rdchk_b("b fm cfg", ADDR_FM_CFG, 8'h29);
      rdchk_b("b mask", ADDR_FAULT_MASK, 8'h10);
      @(posedge mclk);
      #1;
      init_done_b = 1'b1;
      init_result = 8'h71;
      @(posedge mclk);
      #1;
      init_done_b = 1'b0;
      init_result = 8'h00;
      idle(3);
      rdchk_b("b startup", ADDR_STARTUP_STATUS, 8'h01);
      chk1("b startup fault", 1'b1, fault_out_b);
      chk1("b held", 1'b0, run_mode_b);
      ledfs_host_model_b_inst.wr(ADDR_DEV_CONFIG, 8'h01);
      idle(3);
      chk1("b runs", 1'b1, run_mode_b);
      chk1("b fault clear", 1'b0, fault_out_b);
      alarm.otea = 1'b1;
      idle(2);
      chk1("b early alert masked", 1'b0, fault_out_b);
      alarm.thsd = 1'b1;
      idle(2);
      chk1("b shutdown shown", 1'b1, fault_out_b);
      alarm = '0;
      idle(2);
      chk1("b real time", 1'b0, fault_out_b);
      rdchk_b("b flags latched", ADDR_DEV_STATUS, 8'h12);
      det(8'h08);
      chk8("b disconnected", 8'h07, {4'h0, chan_active_b});
      chk1("b open shown", 1'b1, fault_out_b);
      rdchk_b("b open reported", ADDR_CHAN_STATUS, 8'h08);
      $display("test standalone done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // reset, then the scenarios in turn
   initial begin
      rst = 1'b1;
      det_valid = 1'b0;
      det_result = 8'h00;
      init_done = 1'b0;
      init_done_b = 1'b0;
      init_result = 8'h00;
      alarm = '0;
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_reset();
      t_startup();
      t_detect();
      t_disconnect();
      t_standalone();
      test_done();
   end
   // hang guard, far beyond the some 150 cycles the scenarios need
   initial begin
      #100000;
      num_errors++;
      test_done();
   end
endmodule
